// ===== fspi_device.sv
/*
 Device end: streaming controller around the filter datapath. Takes
 samples on a sink link, checks packet framing, passes each sample that
 passes those checks to the datapath with its channel, and drives results on a source link.
 Assumes the datapath accepts one sample a cycle on dp_in_* and returns
 results on dp_res_* as pulses; it reads dp_stall_r one edge late, so up
 to two results may follow a stall and a two-entry skid absorbs them.
 Coefficient reload and set selection stay outside this block.
*/
// How it works
// - Beat moves only when ready and valid
// - Held output stays steady until accepted
// - Valid low when nothing to send
// - Low ready stalls the sender
// - Integrator may tie downstream ready high
// - Packets marked by first and last flags
// - Every result carries its channel index
// - Input channel inferred from packet position
// - Error codes: none, no first, no last, other
// - Error stays zero in normal operation
// - On error reset controller, await first flag
// - Upstream error forwarded to output error
// - Error leaves filter datapath untouched
// - System should reset filter on error
// - Coefficient ports lie outside this interface
// - First-flag beat is channel zero
// - Last flag on channel N-1 beat
module fspi_device
   import fspi_pkg::*;
#(
   parameter int symbol_bit_width = FSPI_DEF_WIDTH,
   parameter int CHANNELS = FSPI_DEF_CHANNELS,
   parameter int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1
)
(
   input wire logic clk,
   input wire logic rst,
   fspi_if.snk sink,
   fspi_if.src source,
   output logic dp_in_valid_r,
   output logic [symbol_bit_width-1:0] dp_in_data_r,
   output logic [CH_W-1:0] dp_in_channel_r,
   input wire logic dp_res_valid,
   input wire logic [symbol_bit_width-1:0] dp_res_data,
   input wire logic [CH_W-1:0] dp_res_channel,
   output logic dp_stall_r
);

   // Elaboration check on parameters
   initial
   begin
      if (CHANNELS < 1 || symbol_bit_width < 1)
         $error("fspi_device: bad CHANNELS or symbol_bit_width");
      if (CH_W < ((CHANNELS > 1) ? $clog2(CHANNELS) : 1))
         $error("fspi_device: CH_W too narrow");
   end

   // Controller states
   typedef enum logic [0:0] {
      FSPI_HUNT = 1'b0, // Discard until first flag
      FSPI_RUN = 1'b1 // Inside a packet
   } fspi_state_t;

   localparam logic [CH_W-1:0] LAST_CH = CH_W'(CHANNELS - 1);
   localparam logic [CH_W-1:0] CH_ZERO = '0;

   fspi_state_t state_r, state_nxt; // Framing state
   logic [CH_W-1:0] ch_r, ch_nxt; // Expected channel of next beat
   // Two-bit error code shown downstream
   logic [FSPI_ERR_W-1:0] err_r, err_nxt;
   logic sink_ready_r; // Registered ready to upstream
   // Output holding register
   logic out_valid_r;
   logic [symbol_bit_width-1:0] out_data_r;
   logic [CH_W-1:0] out_ch_r;
   // Parked results, oldest in entry zero
   logic [symbol_bit_width-1:0] skid_data_r [FSPI_SKID_DEPTH];
   logic [CH_W-1:0] skid_ch_r [FSPI_SKID_DEPTH];
   logic [1:0] skid_cnt_r; // Number of parked results

   // Handshake decode
   wire logic in_fire = sink_ready_r & sink.valid;
   wire logic out_fire = out_valid_r & source.ready;
   // Upstream error counts only on a transferred beat
   wire logic up_err = in_fire & (sink.error != FSPI_ERR_NONE);
   wire logic at_last = (ch_r == LAST_CH);
   // Last flag due on this beat: a first-flag beat is channel zero
   wire logic eop_due = sink.sop ? (LAST_CH == CH_ZERO) : at_last;
   // Framing faults seen on an accepted beat
   wire logic miss_sop = in_fire & (state_r == FSPI_HUNT) & ~sink.sop & sink.eop;
   wire logic miss_eop = in_fire & (state_r == FSPI_RUN) & sink.sop;
   wire logic bad_eop = in_fire & ((state_r == FSPI_RUN) | sink.sop)
      & (sink.eop != eop_due);
   wire logic own_err = miss_eop | bad_eop | miss_sop;
   // Accepted sample feeds datapath: first flag always restarts at zero
   wire logic take = in_fire & ~up_err & ~miss_eop & ~bad_eop
      & (sink.sop | state_r == FSPI_RUN);
   wire logic take_ch_is0 = sink.sop;
   // Output stage can absorb a result this cycle
   wire logic out_free = ~out_valid_r | source.ready;
   // Skid bookkeeping: a result parks unless it goes straight to the output
   wire logic skid_pop = out_free & (skid_cnt_r != 2'h0);
   wire logic skid_push = dp_res_valid & ~(out_free & (skid_cnt_r == 2'h0));
   wire logic [1:0] skid_cnt_nxt = skid_cnt_r - {1'b0, skid_pop} + {1'b0, skid_push};
   // Slot that a parked result goes to, after any shift
   wire logic skid_wr_idx = 1'(skid_cnt_r - {1'b0, skid_pop});

   // Framing state machine and error code
   always_comb
   begin
      state_nxt = state_r;
      ch_nxt = ch_r;
      err_nxt = FSPI_ERR_NONE;
      if (up_err)
      begin
         // Upstream error: restart and pass code on
         state_nxt = FSPI_HUNT;
         ch_nxt = CH_ZERO;
         err_nxt = sink.error;
      end
      else if (own_err)
      begin
         // Own framing fault: restart and report
         state_nxt = FSPI_HUNT;
         ch_nxt = CH_ZERO;
         if (miss_sop)
            err_nxt = FSPI_ERR_NO_SOP;
         else if (miss_eop)
            err_nxt = FSPI_ERR_NO_EOP;
         else
            err_nxt = FSPI_ERR_OTHER;
      end
      else if (take)
      begin
         // Track channel by position only
         if (sink.eop)
         begin
            state_nxt = FSPI_HUNT;
            ch_nxt = CH_ZERO;
         end
         else
         begin
            state_nxt = FSPI_RUN;
            ch_nxt = take_ch_is0 ? CH_W'(1) : CH_W'(ch_r + CH_W'(1));
         end
      end
   end

   // Channel of the sample now accepted
   wire logic [CH_W-1:0] take_ch = take_ch_is0 ? CH_ZERO : ch_r;

   // Controller registers only; the datapath is never reset here
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= FSPI_HUNT;
         ch_r <= CH_ZERO;
         err_r <= FSPI_ERR_NONE;
      end
      else
      begin
         state_r <= state_nxt;
         ch_r <= ch_nxt;
         err_r <= err_nxt;
      end
   end

   // Sample towards datapath
   always_ff @(posedge clk)
   begin
      if (rst)
         dp_in_valid_r <= 1'b0;
      else
         dp_in_valid_r <= take;
      dp_in_data_r <= sink.data;
      dp_in_channel_r <= take_ch;
   end

   // Accept upstream only while no result is parked
   always_ff @(posedge clk)
   begin
      if (rst)
         sink_ready_r <= FSPI_RST_READY;
      else
         sink_ready_r <= (skid_cnt_nxt == 2'h0);
   end

   // Stall datapath once a result is parked; one more still fits
   always_ff @(posedge clk)
   begin
      if (rst)
         dp_stall_r <= 1'b0;
      else
         dp_stall_r <= (skid_cnt_nxt != 2'h0);
   end

   // Output register, fed from the skid first, then from a fresh result
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         out_valid_r <= FSPI_RST_VALID;
         skid_cnt_r <= FSPI_RST_SKID_CNT;
      end
      else
      begin
         skid_cnt_r <= skid_cnt_nxt;
         // Held result stays steady until taken
         if (out_free)
         begin
            out_valid_r <= skid_pop | dp_res_valid;
            out_data_r <= skid_pop ? skid_data_r[0] : dp_res_data;
            out_ch_r <= skid_pop ? skid_ch_r[0] : dp_res_channel;
         end
      end
   end

   // Skid storage: shift on pop, park a result in the first free slot
   always_ff @(posedge clk)
   begin
      if (skid_pop)
      begin
         skid_data_r[0] <= skid_data_r[1];
         skid_ch_r[0] <= skid_ch_r[1];
      end
      if (skid_push)
      begin
         skid_data_r[skid_wr_idx] <= dp_res_data;
         skid_ch_r[skid_wr_idx] <= dp_res_channel;
      end
   end

   // Drive links
   assign sink.ready = sink_ready_r;
   assign source.valid = out_valid_r;
   assign source.data = out_data_r;
   assign source.channel = out_ch_r;
   assign source.sop = out_valid_r & (out_ch_r == CH_ZERO);
   assign source.eop = out_valid_r & (out_ch_r == LAST_CH);
   assign source.error = err_r;
endmodule

// ===== fspi_if.sv
/*
 Interface joining one streaming source and one streaming sink.
 Assumes both parties run on the same clock; no clocking block.
*/
interface fspi_if
   import fspi_pkg::*;
#(
   parameter int symbol_bit_width = FSPI_DEF_WIDTH,
   parameter int CH_W = 2
)
();
   logic ready; // Sink to source
   logic valid; // Source to sink
   logic [symbol_bit_width-1:0] data; // One symbol each beat
   logic [CH_W-1:0] channel; // Channel index
   logic sop; // First beat of packet
   logic eop; // Last beat of packet
   logic [FSPI_ERR_W-1:0] error; // Error code

   // Sending party
   modport src (input ready, output valid, output data, output channel,
      output sop, output eop, output error);
   // Receiving party
   modport snk (output ready, input valid, input data, input channel,
      input sop, input eop, input error);
endinterface

// ===== fspi_partner.sv
/*
 Partner end: upstream sample source and downstream result sink.
 Sends packets of CHANNELS samples from a user push port and hands
 results to the user. Assumes the device on the other links.
*/
module fspi_partner
   import fspi_pkg::*;
#(
   parameter int symbol_bit_width = FSPI_DEF_WIDTH,
   parameter int CHANNELS = FSPI_DEF_CHANNELS,
   parameter int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1
)
(
   input wire logic clk,
   input wire logic rst,
   fspi_if.src to_dev,
   fspi_if.snk from_dev,
   input wire logic usr_push,
   input wire logic [symbol_bit_width-1:0] usr_data,
   input wire logic [FSPI_ERR_W-1:0] usr_err,
   output logic usr_busy_r,
   input wire logic usr_take_ready,
   output logic usr_res_valid_r,
   output logic [symbol_bit_width-1:0] usr_res_data_r,
   output logic [CH_W-1:0] usr_res_channel_r,
   output logic [FSPI_ERR_W-1:0] usr_res_err_r
);

   // Elaboration check
   initial
   begin
      if (CHANNELS < 1 || symbol_bit_width < 1)
         $error("fspi_partner: bad parameters");
   end

   localparam logic [CH_W-1:0] LAST_CH = CH_W'(CHANNELS - 1);

   logic valid_r; // Beat on offer
   logic [symbol_bit_width-1:0] data_r;
   logic sop_r, eop_r;
   logic [FSPI_ERR_W-1:0] err_r;
   logic [CH_W-1:0] pos_r; // Position in packet
   logic rdy_r; // Result-side ready

   wire logic send_fire = valid_r & to_dev.ready;
   wire logic load = usr_push & (~valid_r | send_fire);

   // Source side: hold beat until accepted
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         valid_r <= 1'b0;
         pos_r <= '0;
         err_r <= FSPI_ERR_NONE;
      end
      else if (load)
      begin
         valid_r <= 1'b1;
         data_r <= usr_data;
         sop_r <= (pos_r == '0);
         eop_r <= (pos_r == LAST_CH);
         err_r <= usr_err;
         pos_r <= (pos_r == LAST_CH) ? '0 : CH_W'(pos_r + CH_W'(1));
      end
      else if (send_fire)
         valid_r <= 1'b0;
   end

   // Busy while a beat is held, so a push seen low-busy always loads
   always_ff @(posedge clk)
   begin
      if (rst)
         usr_busy_r <= 1'b0;
      else
         usr_busy_r <= load | (valid_r & ~send_fire);
   end

   // Sink side: valid only on handshake; data, channel and error taken each cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdy_r <= 1'b0;
         usr_res_valid_r <= 1'b0;
         usr_res_err_r <= FSPI_ERR_NONE;
      end
      else
      begin
         rdy_r <= usr_take_ready;
         usr_res_valid_r <= rdy_r & from_dev.valid;
         usr_res_err_r <= from_dev.error;
      end
      usr_res_data_r <= from_dev.data;
      usr_res_channel_r <= from_dev.channel;
   end

   // Drive links
   assign to_dev.valid = valid_r;
   assign to_dev.data = data_r;
   assign to_dev.channel = '0; // Not read by device
   assign to_dev.sop = sop_r;
   assign to_dev.eop = eop_r;
   assign to_dev.error = valid_r ? err_r : FSPI_ERR_NONE;
   assign from_dev.ready = rdy_r;
endmodule

// ===== fspi_pkg.sv
/*
 Shared constants for the streaming packet interface: error codes
 and widths used by both ends, and reset values used by the device end.
 Assumes a single 50 MHz clock and a synchronous active-high reset.
*/
package fspi_pkg;
   // Error code width and encodings
   localparam int FSPI_ERR_W = 2;
   localparam logic [1:0] FSPI_ERR_NONE = 2'h0;
   localparam logic [1:0] FSPI_ERR_NO_SOP = 2'h1;
   localparam logic [1:0] FSPI_ERR_NO_EOP = 2'h2;
   localparam logic [1:0] FSPI_ERR_OTHER = 2'h3;
   // Handshake timing
   localparam int FSPI_READY_LATENCY = 0;
   localparam int FSPI_SYMBOLS_EACH_BEAT = 1;
   // Defaults
   localparam int FSPI_DEF_WIDTH = 16;
   localparam int FSPI_DEF_CHANNELS = 4;
   // Reset values
   localparam logic FSPI_RST_VALID = 1'b0;
   localparam logic FSPI_RST_READY = 1'b0;
   localparam logic [1:0] FSPI_RST_SKID_CNT = 2'h0;
   // Result slots behind the output register: covers two results launched
   // by the datapath before a registered stall reaches it
   localparam int FSPI_SKID_DEPTH = 2;
endpackage

// ===== fspi_sva.sv
/*
 Checker for both links between the partner and the device end.
 Assumes one clock and a synchronous active-high reset.
*/
module fspi_sva
   import fspi_pkg::*;
#(
   parameter int symbol_bit_width = 16,
   parameter int CHANNELS = 4,
   parameter int CH_W = 2
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic [symbol_bit_width-1:0] in_data,
   input wire logic in_sop,
   input wire logic in_eop,
   input wire logic [1:0] in_error,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [symbol_bit_width-1:0] out_data,
   input wire logic [CH_W-1:0] out_channel,
   input wire logic out_sop,
   input wire logic out_eop,
   input wire logic [1:0] out_error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Beat taken by the device
   sequence in_beat;
      in_valid && in_ready;
   endsequence
   // Taken beat carrying an upstream error
   sequence in_bad;
      in_beat ##0 in_error != FSPI_ERR_NONE;
   endsequence
   in_hold_a: assert property (in_valid && !in_ready |=> in_valid &&
      $stable(in_data) && $stable({in_sop, in_eop, in_error}))
      else $error("input beat changed while stalled");
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid &&
      $stable(out_data) && $stable(out_channel)) else $error("result changed while stalled");
   out_sop_a: assert property (out_valid |-> out_sop == (out_channel == '0))
      else $error("first flag not on channel zero");
   out_eop_a: assert property (out_valid |->
      out_eop == (out_channel == CH_W'(CHANNELS - 1))) else $error("last flag misplaced");
   err_fwd_a: assert property (in_bad |=> out_error == $past(in_error))
      else $error("upstream error not forwarded");
   err_cause_a: assert property (out_error != FSPI_ERR_NONE |->
      $past(in_valid && in_ready)) else $error("error without a taken beat");
   rst_quiet_a: assert property (disable iff (1'b0) rst |=> !out_valid && !in_ready)
      else $error("link active in reset");
   in_frame_a: assert property (in_valid && in_sop |-> !in_eop)
      else $error("first and last flag together");
endmodule

// ===== test_fir_stream_packet_interface.sv
/*
 End-to-end bench: partner and device joined, datapath looped back.
 Assumes package, interface, both ends and checker compiled first.
*/
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_fir_stream_packet_interface
   import fspi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 16; // Sample width
   localparam int CHN = 4; // Channels
   localparam int CW = 2; // Channel index width
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic usr_push = 1'b0;
   logic [W-1:0] usr_data = 16'h0000;
   logic [1:0] usr_err = 2'h0;
   logic usr_take_ready = 1'b1;
   logic stall_on = 1'b0; // Random backpressure switch
   logic usr_busy_r, usr_res_valid_r, dp_in_valid_r, dp_stall_r;
   logic [W-1:0] usr_res_data_r, dp_in_data_r;
   logic [CW-1:0] usr_res_channel_r, dp_in_channel_r;
   logic [1:0] usr_res_err_r;
   logic [W+CW-1:0] exp_res; // Oldest expected result
   logic [1:0] exp_err; // Oldest expected error code
   logic dp_res_valid = 1'b0;
   logic [W-1:0] dp_res_data = 16'h0000;
   logic [CW-1:0] dp_res_channel = 2'h0;
   logic [W+CW-1:0] dpq[$]; // Samples inside the datapath
   logic [W+CW-1:0] exq[$]; // Expected results
   logic [1:0] erq[$]; // Expected error codes
   int seed = 14658;
   int num_errors = 0;
   int n_compared = 0;
   fspi_if #(.symbol_bit_width(W), .CH_W(CW)) link_in();
   fspi_if #(.symbol_bit_width(W), .CH_W(CW)) link_out();
   fspi_partner #(.symbol_bit_width(W), .CHANNELS(CHN)) i_fspi_partner (.clk(clk),
      .rst(rst), .to_dev(link_in), .from_dev(link_out), .usr_push(usr_push),
      .usr_data(usr_data), .usr_err(usr_err), .usr_busy_r(usr_busy_r),
      .usr_take_ready(usr_take_ready), .usr_res_valid_r(usr_res_valid_r),
      .usr_res_data_r(usr_res_data_r), .usr_res_channel_r(usr_res_channel_r),
      .usr_res_err_r(usr_res_err_r));
   fspi_device #(.symbol_bit_width(W), .CHANNELS(CHN)) i_fspi_device (.clk(clk),
      .rst(rst), .sink(link_in), .source(link_out), .dp_in_valid_r(dp_in_valid_r),
      .dp_in_data_r(dp_in_data_r), .dp_in_channel_r(dp_in_channel_r),
      .dp_res_valid(dp_res_valid), .dp_res_data(dp_res_data),
      .dp_res_channel(dp_res_channel), .dp_stall_r(dp_stall_r));
   fspi_sva #(.symbol_bit_width(W), .CHANNELS(CHN), .CH_W(CW)) i_fspi_sva (.clk(clk),
      .rst(rst), .in_valid(link_in.valid), .in_ready(link_in.ready),
      .in_data(link_in.data), .in_sop(link_in.sop), .in_eop(link_in.eop),
      .in_error(link_in.error), .out_valid(link_out.valid), .out_ready(link_out.ready),
      .out_data(link_out.data), .out_channel(link_out.channel), .out_sop(link_out.sop),
      .out_eop(link_out.eop), .out_error(link_out.error));
   // Clock, 20 ns period
   initial
   begin
      forever #10 clk = ~clk;
   end
   // Loop-back datapath, holds results while stalled
   always @(posedge clk)
   begin
      dp_res_valid <= 1'b0;
      if (!dp_stall_r && dpq.size() > 0)
      begin
         dp_res_valid <= 1'b1;
         {dp_res_channel, dp_res_data} <= dpq.pop_front();
      end
      if (dp_in_valid_r)
         dpq.push_back({dp_in_channel_r, dp_in_data_r});
      usr_take_ready <= !stall_on | 1'($random(seed));
   end
   // Result and error monitor
   always @(posedge clk)
   begin
      if (!rst && usr_res_valid_r !== 1'b0)
      begin
         exp_res = exq.pop_front();
         `CHK({usr_res_channel_r, usr_res_data_r}, exp_res)
      end
      if (!rst && usr_res_err_r !== FSPI_ERR_NONE)
      begin
         exp_err = erq.pop_front();
         `CHK(usr_res_err_r, exp_err)
      end
   end
   // Verdict and end of run
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Bounded wait for a condition sampled at falling edges
   task automatic wait_low(ref logic [W+CW-1:0] q[$], input bit busy);
      int n;
      n = 0;
      while ((busy ? usr_busy_r !== 1'b0 : (q.size() > 0 || erq.size() > 0)) && n < 2000)
      begin
         n++;
         @(negedge clk);
      end
      if (n == 2000)
      begin
         num_errors++;
         final_report();
      end
   endtask
   // One beat through the partner push port
   task automatic push_beat(input logic [W-1:0] d, input logic [1:0] e);
      @(negedge clk);
      wait_low(exq, 1'b1);
      @(posedge clk);
      usr_push <= 1'b1;
      usr_data <= d;
      usr_err <= e;
      @(posedge clk);
      usr_push <= 1'b0;
   endtask
   // Whole packet, error code on its first beat only
   task automatic packet(input logic [1:0] e);
      logic [W-1:0] d;
      for (int c = 0; c < CHN; c++)
      begin
         d = W'($random(seed));
         if (e == FSPI_ERR_NONE)
            exq.push_back({CW'(c), d});
         push_beat(d, (c == 0) ? e : FSPI_ERR_NONE);
      end
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      repeat (3) packet(FSPI_ERR_NONE);
      wait_low(exq, 1'b0);
      $display("test plain done");
      stall_on <= 1'b1;
      repeat (4) packet(FSPI_ERR_NONE);
      wait_low(exq, 1'b0);
      stall_on <= 1'b0;
      $display("test backpressure done");
      for (int e = 1; e < 4; e++)
      begin
         erq.push_back(2'(e));
         erq.push_back(FSPI_ERR_NO_SOP);
         packet(2'(e));
         packet(FSPI_ERR_NONE);
      end
      wait_low(exq, 1'b0);
      repeat (20) @(posedge clk);
      $display("test errors done");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      packet(FSPI_ERR_NONE);
      wait_low(exq, 1'b0);
      $display("test reset done");
      final_report();
   end
endmodule
